// file: verilog/burst_wrap_ecc_status_cfg.sv
// Behaviour
// - Reset loads live drive from boot copy
// - Drive code decodes to seven strength ranks
// - Wrap bit inverted, boot default disabled
// - Only quad and DDR quad reads wrap
// - Wrap length field selects 8 to 64
// - Boot wrap setting active straight after reset
// - Live wrap write takes effect immediately
// - Live drive write changes drive, no reset
// - Accept register read, write, burst length
// - ECC status read only, writes ignored
// - ECC read returns selected unit status
// - Bit 2 flags check-bit correction
// - Bit 1 flags data correction
// - Bit 0 flags correction disabled
// - Status bits reset to zero
// - Upper status bits reserved, read as zero
// - Register and ECC reads never wrap
// - Reset copies whole boot byte to live
`timescale 1ns/1ps
module burst_wrap_ecc_status_cfg #(
    parameter int NUM_UNITS  = 16,
    parameter int UNIT_SHIFT = 4,
    parameter int UNIT_W     = $clog2(NUM_UNITS)
) (
    input  wire logic              clock,
    input  wire logic              arst_n,
    input  wire logic              sck,
    input  wire logic              cs_n,
    input  wire logic              si,
    input  wire logic              ecc_valid,
    input  wire logic [UNIT_W-1:0] ecc_unit,
    input  wire logic              ecc_check_fix,
    input  wire logic              ecc_data_fix,
    input  wire logic              ecc_off,
    output logic                   so_q,
    output logic                   so_oe_q,
    output logic [2:0]             drive_rank_q,
    output logic                   wrap_on_q,
    output logic [23:0]            rd_addr_q,
    output logic                   rd_wrap_q
);

    spi_byte_if link_if ();

    spi_byte_link u_link (
        .sck     (sck),
        .arst_n  (arst_n),
        .cs_n    (cs_n),
        .si      (si),
        .so_q    (so_q),
        .so_oe_q (so_oe_q),
        .bus     (link_if.link)
    );

    cfg4_pkg::cmd_state_t state_q;
    logic              cs_s1_q, cs_s2_q, cs_s3_q;
    logic              tg_s1_q, tg_s2_q, tg_s3_q;
    logic              byte_evt, addr_done, data_evt, sw_rst, load_q;
    logic              rst_en_q, wr_any, live_wr, boot_wr, tx_en_q;
    logic              is_read, is_quad, is_ecc, needs_dummy;
    logic [7:0]        rx, opcode_q, boot_q, live_q, tx_q;
    logic [2:0]        cnt_q;
    logic [23:0]       addr_q, full_addr, base_q, mask_q, wrap_mask;
    logic [UNIT_W-1:0] sel_unit;
    logic [2:0]        ecc_stat_q [NUM_UNITS];

    assign link_if.tx_byte = tx_q;
    assign link_if.tx_en   = tx_en_q;

    // ------------------------------------------------------------
    // Crossing from link clock
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            tg_s1_q <= 1'b0;
            tg_s2_q <= 1'b0;
            tg_s3_q <= 1'b0;
        end else begin
            cs_s1_q <= cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            tg_s1_q <= link_if.rx_tgl;
            tg_s2_q <= tg_s1_q;
            tg_s3_q <= tg_s2_q;
        end
    end

    assign byte_evt  = tg_s2_q ^ tg_s3_q;
    assign rx        = link_if.rx_byte;
    assign full_addr = {addr_q[15:0], rx};
    assign addr_done = byte_evt && (state_q == cfg4_pkg::ST_ADDR)
                       && (cnt_q == cfg4_pkg::ADDR_LAST);
    assign data_evt  = byte_evt && (state_q == cfg4_pkg::ST_DATA);
    assign is_quad   = (opcode_q == cfg4_pkg::OP_READ_QUAD_IO)
                       || (opcode_q == cfg4_pkg::OP_READ_DDR_QUAD);
    assign is_read   = is_quad || (opcode_q == cfg4_pkg::OP_READ_SERIAL);
    assign is_ecc    = (opcode_q == cfg4_pkg::OP_ECC_READ_A)
                       || (opcode_q == cfg4_pkg::OP_ECC_READ_B);
    assign needs_dummy = is_ecc
                       || (opcode_q == cfg4_pkg::OP_READ_ANY_REG);
    assign sel_unit  = full_addr[UNIT_SHIFT +: UNIT_W];

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q  <= cfg4_pkg::ST_OPCODE;
            opcode_q <= 8'h00;
            cnt_q    <= cfg4_pkg::CNT_ZERO;
        end else if (byte_evt) begin
            case (state_q)
                cfg4_pkg::ST_OPCODE: begin
                    opcode_q <= rx;
                    cnt_q    <= cfg4_pkg::CNT_ZERO;
                    if (rx == cfg4_pkg::OP_READ_ANY_REG
                        || rx == cfg4_pkg::OP_WRITE_ANY_REG
                        || rx == cfg4_pkg::OP_ECC_READ_A
                        || rx == cfg4_pkg::OP_ECC_READ_B
                        || rx == cfg4_pkg::OP_READ_SERIAL
                        || rx == cfg4_pkg::OP_READ_QUAD_IO
                        || rx == cfg4_pkg::OP_READ_DDR_QUAD) begin
                        state_q <= cfg4_pkg::ST_ADDR;
                    end else if (rx == cfg4_pkg::OP_SET_BURST_LEN) begin
                        state_q <= cfg4_pkg::ST_DATA;
                    end else begin
                        state_q <= cfg4_pkg::ST_SKIP;
                    end
                end
                cfg4_pkg::ST_ADDR: begin
                    if (cnt_q == cfg4_pkg::ADDR_LAST) begin
                        cnt_q   <= cfg4_pkg::CNT_ZERO;
                        state_q <= needs_dummy ? cfg4_pkg::ST_DUMMY
                                               : cfg4_pkg::ST_DATA;
                    end else begin
                        cnt_q <= cnt_q + cfg4_pkg::CNT_ONE;
                    end
                end
                cfg4_pkg::ST_DUMMY: state_q <= cfg4_pkg::ST_DATA;
                cfg4_pkg::ST_DATA:  cnt_q   <= cfg4_pkg::CNT_ONE;
                default:            state_q <= cfg4_pkg::ST_SKIP;
            endcase
        end else if (cs_s3_q) begin
            state_q <= cfg4_pkg::ST_OPCODE;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            addr_q <= 24'h000000;
        end else if (byte_evt && state_q == cfg4_pkg::ST_ADDR) begin
            addr_q <= full_addr;
        end
    end

    // ------------------------------------------------------------
    // Software reset pair
    // ------------------------------------------------------------
    assign sw_rst = byte_evt && state_q == cfg4_pkg::ST_OPCODE
                    && rx == cfg4_pkg::OP_RESET && rst_en_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_en_q <= 1'b0;
        end else if (byte_evt && state_q == cfg4_pkg::ST_OPCODE) begin
            rst_en_q <= (rx == cfg4_pkg::OP_RESET_ENABLE);
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    assign wr_any  = data_evt && cnt_q == cfg4_pkg::CNT_ZERO
                     && opcode_q == cfg4_pkg::OP_WRITE_ANY_REG;
    assign boot_wr = wr_any && addr_q == cfg4_pkg::ADDR_BOOT_CFG;
    assign live_wr = (wr_any && addr_q == cfg4_pkg::ADDR_LIVE_CFG)
                     || (data_evt && cnt_q == cfg4_pkg::CNT_ZERO
                         && opcode_q == cfg4_pkg::OP_SET_BURST_LEN);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            boot_q <= cfg4_pkg::CFG_FACTORY;
        end else if (boot_wr) begin
            boot_q <= rx & cfg4_pkg::CFG_WMASK;
        end
    end

    // Live copy loads from boot copy one edge after any reset
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            load_q <= 1'b1;
        end else begin
            load_q <= sw_rst;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            live_q <= cfg4_pkg::CFG_FACTORY;
        end else if (load_q) begin
            live_q <= boot_q;
        end else if (live_wr) begin
            live_q <= rx & cfg4_pkg::CFG_WMASK;
        end
    end

    function automatic logic [2:0] drive_rank(input logic [2:0] code);
        case (code)
            3'h1:    drive_rank = cfg4_pkg::RANK_WEAKEST;
            3'h2:    drive_rank = 3'h1;
            3'h0, 3'h3: drive_rank = cfg4_pkg::RANK_NOMINAL;
            3'h4:    drive_rank = 3'h3;
            3'h5:    drive_rank = 3'h4;
            3'h6:    drive_rank = 3'h5;
            default: drive_rank = cfg4_pkg::RANK_STRONG;
        endcase
    endfunction

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            drive_rank_q <= cfg4_pkg::RANK_NOMINAL;
            wrap_on_q    <= 1'b0;
        end else begin
            drive_rank_q <= drive_rank(
                live_q[cfg4_pkg::DRV_LSB +: cfg4_pkg::DRV_W]);
            wrap_on_q    <= ~live_q[cfg4_pkg::WRAP_OFF_BIT];
        end
    end

    // ------------------------------------------------------------
    // ECC unit status, set only by the ECC engine
    // ------------------------------------------------------------
    for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                ecc_stat_q[u] <= cfg4_pkg::ECC_RESET;
            end else if (ecc_valid && ecc_unit == UNIT_W'(u)) begin
                ecc_stat_q[u] <= {ecc_check_fix, ecc_data_fix, ecc_off};
            end
        end
    end

    // ------------------------------------------------------------
    // Response byte, held stable through the dummy byte
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tx_q    <= 8'h00;
            tx_en_q <= 1'b0;
        end else if (addr_done && is_ecc) begin
            tx_q    <= {cfg4_pkg::ECC_RSVD_VAL, ecc_stat_q[sel_unit]};
            tx_en_q <= 1'b1;
        end else if (addr_done && opcode_q == cfg4_pkg::OP_READ_ANY_REG) begin
            tx_en_q <= 1'b1;
            if (full_addr == cfg4_pkg::ADDR_BOOT_CFG) begin
                tx_q <= boot_q;
            end else if (full_addr == cfg4_pkg::ADDR_LIVE_CFG) begin
                tx_q <= live_q;
            end else begin
                tx_q <= 8'h00;
            end
        end else if (byte_evt && state_q == cfg4_pkg::ST_OPCODE) begin
            tx_en_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Array read address, sequential or wrapped
    // ------------------------------------------------------------
    assign wrap_mask = (cfg4_pkg::WRAP_MIN_LEN
                        << live_q[cfg4_pkg::WL_LSB +: cfg4_pkg::WL_W])
                       - cfg4_pkg::ADDR_STEP;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rd_addr_q <= 24'h000000;
            rd_wrap_q <= 1'b0;
            base_q    <= 24'h000000;
            mask_q    <= 24'h000000;
        end else if (addr_done && is_read) begin
            rd_addr_q <= full_addr;
            rd_wrap_q <= is_quad && ~live_q[cfg4_pkg::WRAP_OFF_BIT];
            base_q    <= full_addr & ~wrap_mask;
            mask_q    <= wrap_mask;
        end else if (addr_done) begin
            rd_wrap_q <= 1'b0;
        end else if (data_evt && is_read) begin
            rd_addr_q <= rd_wrap_q
                ? (base_q | ((rd_addr_q + cfg4_pkg::ADDR_STEP) & mask_q))
                : rd_addr_q + cfg4_pkg::ADDR_STEP;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    property p_boot_copy;
        load_q |=> (live_q == $past(boot_q)) ##1
                   (wrap_on_q == ~$past(boot_q[cfg4_pkg::WRAP_OFF_BIT], 2));
    endproperty
    a_boot_copy: assert property (p_boot_copy)
        else $error("live config not loaded from boot copy");
    property p_drive_nominal;
        (live_q[cfg4_pkg::DRV_LSB +: cfg4_pkg::DRV_W] == 3'h0
         || live_q[cfg4_pkg::DRV_LSB +: cfg4_pkg::DRV_W] == 3'h3)
        |=> drive_rank_q == cfg4_pkg::RANK_NOMINAL;
    endproperty
    a_drive_nominal: assert property (p_drive_nominal)
        else $error("codes 000 and 011 differ in strength");
    property p_wrap_write;
        (live_wr && !load_q) |=> ##1
            wrap_on_q == ~$past(rx[cfg4_pkg::WRAP_OFF_BIT], 2);
    endproperty
    a_wrap_write: assert property (p_wrap_write)
        else $error("live wrap write not applied");
    property p_only_quad_wraps;
        (addr_done && !is_quad) |=> !rd_wrap_q;
    endproperty
    a_only_quad_wraps: assert property (p_only_quad_wraps)
        else $error("non quad read entered wrap");
    property p_in_block;
        (rd_wrap_q && data_evt && is_read)
        |=> (rd_addr_q & ~mask_q) == base_q;
    endproperty
    a_in_block: assert property (p_in_block)
        else $error("wrapped address left aligned block");
    property p_ecc_reply;
        (addr_done && is_ecc) |=>
            tx_en_q && tx_q[7:3] == cfg4_pkg::ECC_RSVD_VAL
            && tx_q[2:0] == $past(ecc_stat_q[sel_unit]);
    endproperty
    a_ecc_reply: assert property (p_ecc_reply)
        else $error("ECC reply does not match unit status");
    property p_ecc_set;
        ecc_valid |=> ecc_stat_q[$past(ecc_unit)]
                      == $past({ecc_check_fix, ecc_data_fix, ecc_off});
    endproperty
    a_ecc_set: assert property (p_ecc_set)
        else $error("correction flags not recorded");
    property p_ecc_no_write;
        (!ecc_valid && wr_any)
        |=> ecc_stat_q[sel_unit] == $past(ecc_stat_q[sel_unit]);
    endproperty
    a_ecc_no_write: assert property (p_ecc_no_write)
        else $error("host write changed ECC status");

endmodule

// file: verilog/cfg4_pkg.sv
package cfg4_pkg;

    // ------------------------------------------------------------
    // Command opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_READ_ANY_REG  = 8'h65;
    localparam logic [7:0] OP_WRITE_ANY_REG = 8'h71;
    localparam logic [7:0] OP_SET_BURST_LEN = 8'hC0;
    localparam logic [7:0] OP_ECC_READ_A    = 8'h18;
    localparam logic [7:0] OP_ECC_READ_B    = 8'h19;
    localparam logic [7:0] OP_READ_SERIAL   = 8'h03;
    localparam logic [7:0] OP_READ_QUAD_IO  = 8'hEB;
    localparam logic [7:0] OP_READ_DDR_QUAD = 8'hED;
    localparam logic [7:0] OP_RESET_ENABLE  = 8'h66;
    localparam logic [7:0] OP_RESET         = 8'h99;

    // ------------------------------------------------------------
    // Register addresses and layout
    // ------------------------------------------------------------
    localparam logic [23:0] ADDR_BOOT_CFG = 24'h000005;
    localparam logic [23:0] ADDR_LIVE_CFG = 24'h800005;
    localparam logic [7:0]  CFG_FACTORY   = 8'h10;
    localparam logic [7:0]  CFG_WMASK     = 8'hF3;
    localparam int          DRV_LSB       = 5;
    localparam int          DRV_W         = 3;
    localparam int          WRAP_OFF_BIT  = 4;
    localparam int          WL_LSB        = 0;
    localparam int          WL_W          = 2;
    localparam logic [23:0] WRAP_MIN_LEN  = 24'h000008;
    localparam logic [23:0] ADDR_STEP     = 24'h000001;

    // ------------------------------------------------------------
    // ECC status layout
    // ------------------------------------------------------------
    localparam int         ECC_W        = 3;
    localparam int         ECC_CHK_BIT  = 2;
    localparam int         ECC_DAT_BIT  = 1;
    localparam int         ECC_OFF_BIT  = 0;
    localparam logic [2:0] ECC_RESET    = 3'h0;
    localparam logic [4:0] ECC_RSVD_VAL = 5'h00;

    // ------------------------------------------------------------
    // Framing and drive ranks
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_LAST     = 3'h2;
    localparam logic [2:0] CNT_ZERO      = 3'h0;
    localparam logic [2:0] CNT_ONE       = 3'h1;
    localparam logic [2:0] RANK_WEAKEST  = 3'h0;
    localparam logic [2:0] RANK_NOMINAL  = 3'h2;
    localparam logic [2:0] RANK_STRONG   = 3'h6;

    typedef enum logic [2:0] {
        ST_OPCODE = 3'b000,
        ST_ADDR   = 3'b001,
        ST_DUMMY  = 3'b010,
        ST_DATA   = 3'b011,
        ST_SKIP   = 3'b100
    } cmd_state_t;

endpackage

// file: verilog/spi_byte_if.sv
`timescale 1ns/1ps
interface spi_byte_if;
    logic [7:0] rx_byte;
    logic       rx_tgl;
    logic [7:0] tx_byte;
    logic       tx_en;
    modport link (output rx_byte, output rx_tgl, input tx_byte,
                  input tx_en);
    modport core (input rx_byte, input rx_tgl, output tx_byte,
                  output tx_en);
endinterface

// file: verilog/spi_byte_link.sv
`timescale 1ns/1ps
module spi_byte_link (
    input  wire logic   sck,
    input  wire logic   arst_n,
    input  wire logic   cs_n,
    input  wire logic   si,
    output logic        so_q,
    output logic        so_oe_q,
    spi_byte_if.link    bus
);

    logic       frame_rst_n;
    logic [2:0] bit_q;
    logic [6:0] shin_q;
    logic [6:0] shout_q;
    logic [7:0] hold_q;
    logic       tgl_q;

    assign frame_rst_n = arst_n & ~cs_n;
    assign bus.rx_byte = hold_q;
    assign bus.rx_tgl  = tgl_q;

    // ------------------------------------------------------------
    // Receive on rising edge
    // ------------------------------------------------------------
    always_ff @(posedge sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_q  <= 3'h0;
            shin_q <= 7'h00;
        end else begin
            bit_q  <= bit_q + 3'h1;
            shin_q <= {shin_q[5:0], si};
        end
    end

    // Toggle survives deselect so the core never sees a false edge
    always_ff @(posedge sck or negedge arst_n) begin
        if (!arst_n) begin
            hold_q <= 8'h00;
            tgl_q  <= 1'b0;
        end else if (bit_q == 3'h7) begin
            hold_q <= {shin_q, si};
            tgl_q  <= ~tgl_q;
        end
    end

    // ------------------------------------------------------------
    // Transmit on falling edge, byte loaded at boundary
    // ------------------------------------------------------------
    always_ff @(negedge sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            so_q    <= 1'b0;
            so_oe_q <= 1'b0;
            shout_q <= 7'h00;
        end else if (bit_q == 3'h0) begin
            so_q    <= bus.tx_byte[7];
            so_oe_q <= bus.tx_en;
            shout_q <= bus.tx_byte[6:0];
        end else begin
            so_q    <= shout_q[6];
            shout_q <= {shout_q[5:0], 1'b0};
        end
    end

endmodule

// file: testbench/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so_q,
    input  wire logic so_oe_q
);
    initial begin
        sck  = 1'b0;
        cs_n = 1'b1;
        si   = 1'b0;
    end

    // ------------------------------------------------------------
    // One framed command, mode 0, MSB first
    // ------------------------------------------------------------
    // opcode, address, payload
    task automatic frame(input logic [39:0] tx, input int nb,
                         input int nrd, output logic [7:0] rx,
                         output logic oe);
        oe   = 1'b1;
        rx   = 8'h00;
        cs_n = 1'b0;
        #40;
        for (int i = 0; i < nb * 8; i++) begin
            si = tx[39 - i];
            #40 sck = 1'b1;
            #40 sck = 1'b0;
        end
        // Filler keeps toggling while the device talks
        for (int i = 0; i < nrd * 8; i++) begin
            si = ~si;
            #40 sck = 1'b1;
            // Undriven line reads as the inverse of the last bit
            rx = {rx[6:0], so_oe_q ? so_q : ~so_q};
            oe = oe & so_oe_q;
            #40 sck = 1'b0;
        end
        #40 cs_n = 1'b1;
        si = ~si;
        #400;
    endtask
endmodule

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        clock, arst_n, sck, cs_n, si, ecc_valid;
    logic [3:0]  ecc_unit;
    logic        ecc_check_fix, ecc_data_fix, ecc_off, so_q, so_oe_q;
    logic [2:0]  drive_rank_q;
    logic        wrap_on_q, rd_wrap_q, oe;
    logic [23:0] rd_addr_q, a;
    logic [7:0]  rx, op;
    int          n_fail, n_checks, seed, live_m, boot_m, u, v, len;
    int          ecc_m [16];

    burst_wrap_ecc_status_cfg dut_u (
        .clock, .arst_n, .sck, .cs_n, .si, .ecc_valid, .ecc_unit,
        .ecc_check_fix, .ecc_data_fix, .ecc_off, .so_q, .so_oe_q,
        .drive_rank_q, .wrap_on_q, .rd_addr_q, .rd_wrap_q
    );
    spi_host_model host_u (.sck, .cs_n, .si, .so_q, .so_oe_q);

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic check(input string nm, input logic [23:0] seen,
                         input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic reg_rd(input logic [7:0] o, input logic [23:0] ad);
        host_u.frame({o, ad, 8'h00}, 5, 1, rx, oe);
    endtask

    task automatic reg_wr(input logic [23:0] ad, input int d);
        host_u.frame({cfg4_pkg::OP_WRITE_ANY_REG, ad, d[7:0]}, 5, 0,
                     rx, oe);
    endtask

    task automatic chk_live();
        reg_rd(cfg4_pkg::OP_READ_ANY_REG, cfg4_pkg::ADDR_LIVE_CFG);
        check("live", rx, live_m);
        check("so_oe", oe, 1);
        check("rank", drive_rank_q,
              (live_m[7:5] == 0) ? 2 : live_m[7:5] - 1);
        check("wrap", wrap_on_q, !live_m[4]);
    endtask

    task automatic do_reset();
        @(negedge clock);
        arst_n = 1'b0;
        repeat (4) @(negedge clock);
        arst_n = 1'b1;
        repeat (4) @(negedge clock);
        boot_m = 8'h10;
        live_m = boot_m;
        ecc_m = '{default: 0};
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 39114;
        n_fail = 0;
        n_checks = 0;
        {arst_n, ecc_valid, ecc_check_fix, ecc_data_fix, ecc_off} = '0;
        ecc_unit = '0;
        do_reset();
        chk_live();
        reg_rd(cfg4_pkg::OP_READ_ANY_REG, cfg4_pkg::ADDR_BOOT_CFG);
        check("boot", rx, boot_m);
        reg_rd(cfg4_pkg::OP_READ_ANY_REG, 24'h000001);
        check("unknown", rx, 0);
        for (int c = 0; c < 8; c++) begin
            live_m = {c[2:0], 5'h00} | ($random(seed) & 8'h1F);
            reg_wr(cfg4_pkg::ADDR_LIVE_CFG, live_m);
            live_m &= cfg4_pkg::CFG_WMASK;
            chk_live();
            op = (c % 3 == 0) ? cfg4_pkg::OP_READ_SERIAL :
                 (c % 3 == 1) ? cfg4_pkg::OP_READ_QUAD_IO :
                 cfg4_pkg::OP_READ_DDR_QUAD;
            a = $random(seed);
            host_u.frame({op, a, 8'h00}, 4, 9, rx, oe);
            len = 8 << live_m[1:0];
            if (op != cfg4_pkg::OP_READ_SERIAL && !live_m[4])
                a = (a & ~(len - 1)) | ((a + 9) & (len - 1));
            else
                a = a + 9;
            check("addr", rd_addr_q, a);
            check("rd_wrap", rd_wrap_q,
                  op != cfg4_pkg::OP_READ_SERIAL && !live_m[4]);
        end
        v = $random(seed);
        host_u.frame({cfg4_pkg::OP_SET_BURST_LEN, v[7:0], 24'h0}, 2, 0,
                     rx, oe);
        live_m = v & cfg4_pkg::CFG_WMASK;
        chk_live();
        boot_m = $random(seed) & 8'hE3;
        reg_wr(cfg4_pkg::ADDR_BOOT_CFG, boot_m);
        host_u.frame({cfg4_pkg::OP_RESET_ENABLE, 32'h0}, 1, 0, rx, oe);
        host_u.frame({cfg4_pkg::OP_RESET, 32'h0}, 1, 0, rx, oe);
        live_m = boot_m;
        chk_live();
        for (int k = 0; k < 6; k++) begin
            u = $random(seed) & 15;
            v = $random(seed) & 7;
            @(negedge clock);
            ecc_valid = 1'b1;
            ecc_unit = u[3:0];
            {ecc_check_fix, ecc_data_fix, ecc_off} = v[2:0];
            @(negedge clock);
            ecc_valid = 1'b0;
            ecc_m[u] = v;
            a = {16'h0000, u[3:0], 4'h0};
            reg_wr(a, 8'hFF);
            reg_rd(k[0] ? cfg4_pkg::OP_ECC_READ_B : cfg4_pkg::OP_ECC_READ_A,
                   a);
            // Upper status bits masked off
            check("ecc", rx[2:0], ecc_m[u]);
        end
        do_reset();
        chk_live();
        reg_rd(cfg4_pkg::OP_ECC_READ_A, a);
        check("ecc_rst", rx[2:0], 0);
        give_verdict();
    end

    initial begin
        repeat (100000) @(posedge clock);
        n_fail++;
        give_verdict();
    end
endmodule
